// [smtc_top.sv]
// Purpose: Register side and timing set of a static memory controller
// Assumes: Classic Wishbone slave, 32-bit words, one clock
// Notes: Pin sequencing beyond we/oe strobes lives outside this block
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps

// How it works
// - Capability width field always reads 01, a 16-bit memory bus.
// - Capability chip field reads number of chip selects minus one.
// - Capability type field reads 01 separate mode, 11 multiplexed mode.
// - One bus mode bit picks separate or multiplexed; no change while running.
// - Command bits 25-23 pick chip select 0 to 3; codes 4-7 forbidden.
// - Command type 10 copies staged opmode and cycles into selected chip select.
// - Staged cycles have no effect until an update command is written.
// - Staged opmode also takes effect only on the update command.
// - Three-bit timing fields give one to seven periods; code 0 forbidden.
// - Write cycle field gives 3 to 15 periods; code 0 forbidden.
// - Read cycle field gives 2 to 15 periods; code 0 forbidden.
// - No page accesses in multiplexed mode; page timing only when separate.
// - Multiplexed mode write pulse lasts one period longer than programmed.
// - All timing counts are in controller clock periods, system clock / 2.
module smtc_top #(
  parameter int NCS = 4,
  parameter int ADR_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_acc_req,
  input wire logic [1:0] i_acc_cs,
  input wire logic i_acc_write,
  input wire logic i_acc_page,
  output logic o_acc_ready,
  output logic o_acc_busy,
  output logic o_acc_done,
  output logic o_mem_we,
  output logic o_mem_oe,
  output logic o_mux_mode,
  output logic o_ale_used
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic mux;
    logic [19:0] stg_cyc;
    logic [5:0] stg_op;
    logic [NCS-1:0][19:0] act_cyc;
    logic [NCS-1:0][5:0] act_op;
    logic pend;
    logic [1:0] pend_cs;
    logic [1:0] last_cs;
    logic active;
    logic ready;
    logic start;
    logic write;
    logic page;
    logic [1:0] cs;
    logic ale;
  } smtc_top_state_t;

  smtc_top_state_t r;
  smtc_top_state_t next_r;
  smtc_timer_if tif ();

  logic bus_take;
  logic bus_wr;
  logic [7:0] adr;
  logic cmd_ok;
  logic acc_take;
  logic [19:0] sel_cyc;

  assign adr = 8'(i_wb_adr);
  // Partial-word writes are acked but dropped, registers are word-only
  assign bus_take = i_wb_cyc && i_wb_stb && !r.ack;
  assign bus_wr = bus_take && i_wb_we && (i_wb_sel == 4'hf);
  // Only update commands aimed at an existing chip select count
  assign cmd_ok = (i_wb_dat[smtc_pkg::CMD_TYPE_LSB +: 2] == smtc_pkg::CMD_UPDATE)
    && (i_wb_dat[smtc_pkg::CMD_CS_LSB +: 3] < 3'(NCS));
  // An access waits while an update is pending so it runs on fresh timing
  assign acc_take = i_acc_req && r.ready;
  assign sel_cyc = r.act_cyc[r.cs];

  // ********************************
  // Register and control logic
  // ********************************
  // Bus reply, register writes, update hand-off and access gating
  always_comb begin
    next_r = r;
    next_r.ack = bus_take;
    next_r.start = 1'b0;

    // Read data, unmapped offsets read as zero
    if (bus_take) begin
      next_r.rdat = 32'h0;
      unique case (adr)
        smtc_pkg::ADR_CAPABILITY: begin
          next_r.rdat[smtc_pkg::CAP_WIDTH_LSB +: 2] = smtc_pkg::CAP_WIDTH_16;
          next_r.rdat[smtc_pkg::CAP_CHIPS_LSB +: 2] = 2'(NCS - 1);
          next_r.rdat[smtc_pkg::CAP_TYPE_LSB +: 2] =
            r.mux ? smtc_pkg::CAP_TYPE_MUX : smtc_pkg::CAP_TYPE_SEP;
        end
        smtc_pkg::ADR_BUS_MODE: next_r.rdat[0] = r.mux;
        smtc_pkg::ADR_STATUS: begin
          next_r.rdat[smtc_pkg::STAT_PEND_BIT] = r.pend;
          next_r.rdat[smtc_pkg::STAT_ACTIVE_BIT] = r.active;
          next_r.rdat[smtc_pkg::STAT_CS_LSB +: 2] = r.last_cs;
        end
        default: next_r.rdat = 32'h0;
      endcase
    end

    // Write side: staged values only land in the staging copies
    if (bus_wr) begin
      unique case (adr)
        smtc_pkg::ADR_STAGED_CYC: next_r.stg_cyc = i_wb_dat[19:0];
        smtc_pkg::ADR_STAGED_OP: begin
          next_r.stg_op = {i_wb_dat[smtc_pkg::OP_ADV_BIT],
                           i_wb_dat[smtc_pkg::OP_BL_LSB +: 3],
                           i_wb_dat[smtc_pkg::OP_MW_LSB +: 2]};
        end
        smtc_pkg::ADR_BUS_MODE: begin
          // Mode flips mid-access would corrupt the pin sequence
          if (!r.active) begin
            next_r.mux = i_wb_dat[0];
          end
        end
        default: next_r.rdat = next_r.rdat;
      endcase
    end

    // Apply a pending update only while no access runs
    if (r.pend && !r.active) begin
      next_r.act_cyc[r.pend_cs] = r.stg_cyc;
      next_r.act_op[r.pend_cs] = r.stg_op;
      next_r.last_cs = r.pend_cs;
      next_r.pend = 1'b0;
    end

    // A new command wins over the clear of the old one
    if (bus_wr && (adr == smtc_pkg::ADR_DIRECT_CMD) && cmd_ok) begin
      next_r.pend = 1'b1;
      next_r.pend_cs = i_wb_dat[smtc_pkg::CMD_CS_LSB +: 2];
    end

    // Access request hand-off to the cycle timer
    if (acc_take) begin
      next_r.start = 1'b1;
      next_r.active = 1'b1;
      next_r.write = i_acc_write;
      next_r.page = i_acc_page;
      next_r.cs = i_acc_cs;
      next_r.ale = r.act_op[i_acc_cs][5];
    end else if (tif.done) begin
      next_r.active = 1'b0;
    end
    next_r.ready = !next_r.active && !next_r.pend;
  end

  // State register with defined reset
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      r <= '{act_cyc: {NCS{smtc_pkg::RST_CYCLES}},
             act_op: {NCS{smtc_pkg::RST_OPMODE}},
             stg_cyc: smtc_pkg::RST_CYCLES,
             stg_op: smtc_pkg::RST_OPMODE,
             mux: smtc_pkg::RST_BUS_MODE,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ********************************
  // Cycle timer
  // ********************************
  // Timing is read from the active copy of the chosen chip select
  assign tif.start = r.start;
  assign tif.write = r.write;
  assign tif.page = r.page;
  assign tif.mux = r.mux;
  assign tif.tr = sel_cyc[smtc_pkg::CYC_TR_LSB +: 3];
  assign tif.pc = sel_cyc[smtc_pkg::CYC_PC_LSB +: 3];
  assign tif.wp = sel_cyc[smtc_pkg::CYC_WP_LSB +: 3];
  assign tif.ceoe = sel_cyc[smtc_pkg::CYC_CEOE_LSB +: 3];
  assign tif.wc = sel_cyc[smtc_pkg::CYC_WC_LSB +: 4];
  assign tif.rc = sel_cyc[smtc_pkg::CYC_RC_LSB +: 4];

  smtc_cycle_timer u_timer (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .tif(tif)
  );

  // ********************************
  // Outputs
  // ********************************
  // All come from flip-flops here or in the timer
  assign o_wb_ack = r.ack;
  assign o_wb_dat = r.rdat;
  assign o_acc_ready = r.ready;
  assign o_acc_busy = tif.busy;
  assign o_acc_done = tif.done;
  assign o_mem_we = tif.we;
  assign o_mem_oe = tif.oe;
  assign o_mux_mode = r.mux;
  assign o_ale_used = r.ale;

endmodule

// [smtc_pkg.sv]
// Purpose: Shared constants for the static memory timing configuration block
// Assumes: 32-bit classic Wishbone register port, one 200 MHz clock
// Notes: Offsets are byte addresses of aligned 32-bit words
package smtc_pkg;

  // ********************************
  // Register byte offsets
  // ********************************
  localparam logic [7:0] ADR_CAPABILITY = 8'h04;
  localparam logic [7:0] ADR_DIRECT_CMD = 8'h10;
  localparam logic [7:0] ADR_STAGED_CYC = 8'h14;
  localparam logic [7:0] ADR_STAGED_OP = 8'h18;
  localparam logic [7:0] ADR_BUS_MODE = 8'h1c;
  localparam logic [7:0] ADR_STATUS = 8'h20;

  // ********************************
  // Field positions (least significant bit)
  // ********************************
  localparam int CAP_WIDTH_LSB = 4;
  localparam int CAP_CHIPS_LSB = 2;
  localparam int CAP_TYPE_LSB = 0;
  localparam int CMD_CS_LSB = 23;
  localparam int CMD_TYPE_LSB = 21;
  localparam int CYC_TR_LSB = 17;
  localparam int CYC_PC_LSB = 14;
  localparam int CYC_WP_LSB = 11;
  localparam int CYC_CEOE_LSB = 8;
  localparam int CYC_WC_LSB = 4;
  localparam int CYC_RC_LSB = 0;
  localparam int OP_ADV_BIT = 11;
  localparam int OP_BL_LSB = 3;
  localparam int OP_MW_LSB = 0;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_CS_LSB = 4;

  // ********************************
  // Codes and reset values
  // ********************************
  localparam logic [1:0] CAP_WIDTH_16 = 2'h1;
  localparam logic [1:0] CAP_TYPE_SEP = 2'h1;
  localparam logic [1:0] CAP_TYPE_MUX = 2'h3;
  localparam logic [1:0] CMD_UPDATE = 2'h2;
  localparam logic [19:0] RST_CYCLES = 20'h2b3cc;
  localparam logic [5:0] RST_OPMODE = 6'h01;
  localparam logic RST_BUS_MODE = 1'h0;

  // ********************************
  // Timing
  // ********************************
  localparam int SYS_CLK_MHZ = 200;
  localparam int CTRL_CLK_DIV = 2;  // Controller clock is system clock / 2
  localparam int DIV_W = $clog2(CTRL_CLK_DIV);

  typedef enum logic [2:0] {
    SMTC_S_IDLE = 3'h1,
    SMTC_S_ACT = 3'h2,
    SMTC_S_TURN = 3'h4
  } smtc_state_t;

endpackage

// [smtc_timer_if.sv]
// Purpose: Carries one access request and its timing to the cycle timer
// Assumes: Single clock domain
// Notes: Timing fields are valid in the cycle start is high
`timescale 1ns/1ps
interface smtc_timer_if;
  logic start;
  logic write;
  logic page;
  logic mux;
  logic [2:0] tr;
  logic [2:0] pc;
  logic [2:0] wp;
  logic [2:0] ceoe;
  logic [3:0] wc;
  logic [3:0] rc;
  logic busy;
  logic we;
  logic oe;
  logic done;
  modport ctrl (output start, write, page, mux, tr, pc, wp, ceoe, wc, rc,
                input busy, we, oe, done);
  modport timer (input start, write, page, mux, tr, pc, wp, ceoe, wc, rc,
                 output busy, we, oe, done);
endinterface

// [smtc_cycle_timer.sv]
// Purpose: Times one external access in controller clock periods
// Assumes: start is a one-cycle pulse, only given while busy is low
// Notes: Strobes change only on controller clock ticks
`timescale 1ns/1ps
module smtc_cycle_timer (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  smtc_timer_if.timer tif
);

  typedef struct packed {
    smtc_pkg::smtc_state_t st;
    logic [smtc_pkg::DIV_W-1:0] div;
    logic [3:0] cnt;
    logic [3:0] len;
    logic [3:0] wpe;
    logic [2:0] ceoe;
    logic [2:0] tr;
    logic write;
    logic busy;
    logic we;
    logic oe;
    logic done;
  } smtc_tmr_state_t;

  smtc_tmr_state_t r;
  smtc_tmr_state_t next_r;
  logic tick;
  logic [3:0] p;

  // ********************************
  // Sequencer
  // ********************************
  // Divider gives one enable per controller clock period
  assign tick = (r.div == smtc_pkg::DIV_W'(smtc_pkg::CTRL_CLK_DIV - 1));
  assign p = 4'(r.cnt + 4'h1);

  // Next state of the access sequence
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.div = tick ? '0 : smtc_pkg::DIV_W'(r.div + 1'b1);
    unique case (r.st)
      smtc_pkg::SMTC_S_IDLE: begin
        if (tif.start) begin
          next_r.st = smtc_pkg::SMTC_S_ACT;
          next_r.div = '0;
          next_r.cnt = 4'h0;
          next_r.write = tif.write;
          next_r.busy = 1'b1;
          // Page timing only in separate mode; muxed page reads run full
          if (tif.page && !tif.write && !tif.mux) begin
            next_r.len = {1'b0, tif.pc};
          end else begin
            next_r.len = tif.write ? tif.wc : tif.rc;
          end
          // Muxed writes stretch the pulse one period
          next_r.wpe = {1'b0, tif.wp} + {3'h0, tif.mux};
          next_r.ceoe = tif.ceoe;
          next_r.tr = tif.tr;
        end
      end
      smtc_pkg::SMTC_S_ACT: begin
        if (tick) begin
          if (r.cnt == r.len) begin
            next_r.st = smtc_pkg::SMTC_S_TURN;
            next_r.cnt = 4'h0;
            next_r.we = 1'b0;
            next_r.oe = 1'b0;
          end else begin
            next_r.cnt = p;
            // One setup period before the pulse, hold after it
            next_r.we = r.write && (p >= 4'h2) && (p <= 4'(r.wpe + 4'h1));
            next_r.oe = !r.write && (p > {1'b0, r.ceoe});
          end
        end
      end
      smtc_pkg::SMTC_S_TURN: begin
        if (tick) begin
          next_r.cnt = p;
          if (p[2:0] == r.tr) begin
            next_r.st = smtc_pkg::SMTC_S_IDLE;
            next_r.busy = 1'b0;
            next_r.done = 1'b1;
          end
        end
      end
      default: next_r.st = smtc_pkg::SMTC_S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      r <= '{st: smtc_pkg::SMTC_S_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign tif.busy = r.busy;
  assign tif.we = r.we;
  assign tif.oe = r.oe;
  assign tif.done = r.done;

endmodule

// [smtc_sva.sv]
// Purpose: Port checks for smtc_top
// Assumes: One clock, synchronous active-high reset
// Notes: Only the write strobe width is judged, in whole controller periods
`timescale 1ns/1ps
module smtc_sva #(
  parameter int NCS = 4,
  parameter int ADR_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_acc_req,
  input wire logic o_acc_ready,
  input wire logic o_acc_busy,
  input wire logic o_acc_done,
  input wire logic o_mem_we,
  input wire logic o_mem_oe,
  input wire logic o_mux_mode
);
  // ********
  // Helpers
  // ********
  logic cap_rd;
  logic [7:0] we_run;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // Master still holds address and direction in the ack cycle
  assign cap_rd = o_wb_ack && !i_wb_we && i_wb_adr == ADR_W'(smtc_pkg::ADR_CAPABILITY);
  // Length of the current write strobe in system cycles
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !o_mem_we) begin
      we_run <= 8'h00;
    end else begin
      we_run <= we_run + 8'h01;
    end
  end
  cap_width_a: assert property (cap_rd |-> o_wb_dat[5:4] == 2'h1)
    else $error("capability width wrong");
  cap_chips_a: assert property (cap_rd |-> o_wb_dat[3:2] == 2'(NCS - 1))
    else $error("capability chip count wrong");
  cap_type_a: assert property (cap_rd |-> o_wb_dat[1:0] == (o_mux_mode ? 2'h3 : 2'h1))
    else $error("capability type wrong");
  mode_hold_a: assert property (o_acc_busy |=> $stable(o_mux_mode))
    else $error("bus mode changed during access");
  no_early_a: assert property (o_acc_busy |-> !o_acc_ready)
    else $error("ready while access runs");
  take_seq_a: assert property (i_acc_req && o_acc_ready |=> !o_acc_ready ##1 o_acc_busy)
    else $error("access start sequence wrong");
  ready_back_a: assert property (o_acc_done |-> ##[1:3] o_acc_ready)
    else $error("ready did not return");
  we_whole_a: assert property ($fell(o_mem_we) |-> we_run != 8'h00 && !we_run[0])
    else $error("write strobe not whole periods");
  strobe_busy_a: assert property (o_mem_we || o_mem_oe |-> o_acc_busy)
    else $error("strobe outside access");
  cover property (cap_rd && o_mux_mode);
  cover property (o_acc_done && o_mux_mode);
  cover property ($fell(o_mem_we));
endmodule
bind smtc_top smtc_sva #(.NCS(NCS), .ADR_W(ADR_W)) smtc_sva_inst (.i_sys_clk, .i_srst,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .i_acc_req,
  .o_acc_ready, .o_acc_busy, .o_acc_done, .o_mem_we, .o_mem_oe, .o_mux_mode);

// [smtc_mem_model.sv]
// Purpose: Asynchronous memory seen from its strobes
// Assumes: Strobes are active high
// Notes: Widths are kept until the next pulse ends
`timescale 1ns/1ps
module smtc_mem_model (
  input wire logic i_sys_clk,
  input wire logic i_mem_we,
  input wire logic i_mem_oe,
  output logic [7:0] o_we_len,
  output logic [7:0] o_oe_len
);
  // ********
  // Pulse widths
  // ********
  logic [7:0] we_run = 8'h00;
  logic [7:0] oe_run = 8'h00;
  // The chip only sees widths, so that is what it reports
  always @(posedge i_sys_clk) begin
    we_run <= i_mem_we ? we_run + 8'h01 : 8'h00;
    oe_run <= i_mem_oe ? oe_run + 8'h01 : 8'h00;
    if (!i_mem_we && we_run != 8'h00) begin
      o_we_len <= we_run;
    end
    if (!i_mem_oe && oe_run != 8'h00) begin
      o_oe_len <= oe_run;
    end
  end
endmodule

// [smtc_top_tb.sv]
// Purpose: Self-checking bench for smtc_top
// Assumes: Four chip selects, reset timing set 0x2b3cc
// Notes: Strobe widths come from the memory model, in system cycles
`timescale 1ns/1ps
module smtc_top_tb;
  localparam int NCS = 4;
  logic i_sys_clk, i_srst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
  logic [7:0] i_wb_adr, we_len, oe_len;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  logic i_acc_req, i_acc_write, i_acc_page, o_acc_ready, o_acc_busy, o_acc_done;
  logic o_mem_we, o_mem_oe, o_mux_mode, o_ale_used;
  logic [1:0] i_acc_cs;
  int n_mismatch = 0;
  int n_compared = 0;
  smtc_top #(.NCS(NCS)) smtc_top_inst (.i_sys_clk, .i_srst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_acc_req,
    .i_acc_cs, .i_acc_write, .i_acc_page, .o_acc_ready, .o_acc_busy, .o_acc_done,
    .o_mem_we, .o_mem_oe, .o_mux_mode, .o_ale_used);
  smtc_mem_model smtc_mem_model_inst (.i_sys_clk, .i_mem_we(o_mem_we),
    .i_mem_oe(o_mem_oe), .o_we_len(we_len), .o_oe_len(oe_len));
  // ********
  // Tasks
  // ********
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One classic cycle; held until ack is sampled, then a cycle idle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 50);
    q = o_wb_dat;
    if (n >= 50) n_mismatch++;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  function automatic logic [31:0] cmdw(input logic [2:0] c, input logic [1:0] t);
    return {6'h00, c, t, 21'h000000};
  endfunction
  task automatic acc_go(input logic [1:0] cs, input logic w, input logic pg);
    int n = 0;
    while (o_acc_ready !== 1'b1 && n < 99) begin
      @(posedge i_sys_clk);
      n++;
    end
    // A request that never got ready would leave stale widths to compare
    if (n >= 99) n_mismatch++;
    i_acc_req <= 1'b1;
    i_acc_cs <= cs;
    i_acc_write <= w;
    i_acc_page <= pg;
    @(posedge i_sys_clk);
    i_acc_req <= 1'b0;
  endtask
  task automatic acc_end;
    int n = 0;
    while (o_acc_done !== 1'b1 && n < 300) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 300) n_mismatch++;
    @(posedge i_sys_clk);
  endtask
  // Whole access, then the strobe width it produced
  task automatic run(input logic [1:0] cs, input logic w, input logic pg, input logic [7:0] e);
    acc_go(cs, w, pg);
    acc_end();
    chk(32'(w ? we_len : oe_len), 32'(e));
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  // ********
  // Tests
  // ********
  initial begin
    i_srst <= 1'b1;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_acc_req, i_acc_write, i_acc_page} <= 6'h00;
    i_wb_adr <= 8'h00;
    i_wb_sel <= 4'hf;
    i_wb_dat <= 32'h00000000;
    i_acc_cs <= 2'h0;
    repeat (6) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    wb(1'b0, smtc_pkg::ADR_CAPABILITY, 32'h0);
    chk(32'(q[5:0]), 32'h1d);
    wb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h0);
    run(2'h0, 1'b1, 1'b0, 8'h0c);
    run(2'h0, 1'b0, 1'b0, 8'h12);
    wb(1'b1, smtc_pkg::ADR_STAGED_CYC, 32'h000fc932);
    run(2'h0, 1'b1, 1'b0, 8'h0c);
    for (int i = 0; i < 8; i++) begin
      if (i != 2) wb(1'b1, smtc_pkg::ADR_DIRECT_CMD, cmdw(i < 4 ? 3'h0 : 3'(i), 2'(i)));
    end
    run(2'h0, 1'b1, 1'b0, 8'h0c);
    wb(1'b1, smtc_pkg::ADR_DIRECT_CMD, cmdw(3'h0, smtc_pkg::CMD_UPDATE));
    run(2'h0, 1'b1, 1'b0, 8'h02);
    run(2'h0, 1'b0, 1'b0, 8'h02);
    run(2'h0, 1'b0, 1'b1, 8'h0c);
    run(2'h1, 1'b1, 1'b0, 8'h0c);
    wb(1'b1, smtc_pkg::ADR_STAGED_CYC, 32'h00027fff);
    wb(1'b1, smtc_pkg::ADR_DIRECT_CMD, cmdw(3'h2, smtc_pkg::CMD_UPDATE));
    wb(1'b1, smtc_pkg::ADR_BUS_MODE, 32'h1);
    wb(1'b0, smtc_pkg::ADR_CAPABILITY, 32'h0);
    chk(32'(q[1:0]), 32'h3);
    run(2'h2, 1'b1, 1'b0, 8'h10);
    run(2'h2, 1'b0, 1'b1, 8'h10);
    wb(1'b1, smtc_pkg::ADR_BUS_MODE, 32'h0);
    // Update and mode change arrive while a slow write runs
    acc_go(2'h1, 1'b1, 1'b0);
    repeat (2) @(posedge i_sys_clk);
    wb(1'b1, smtc_pkg::ADR_DIRECT_CMD, cmdw(3'h1, smtc_pkg::CMD_UPDATE));
    // The running access latches its timing, so only status shows the wait
    wb(1'b0, smtc_pkg::ADR_STATUS, 32'h0);
    chk(q, 32'h23);
    wb(1'b1, smtc_pkg::ADR_BUS_MODE, 32'h1);
    acc_end();
    chk(32'(we_len), 32'h0c);
    wb(1'b0, smtc_pkg::ADR_BUS_MODE, 32'h0);
    chk(q, 32'h0);
    run(2'h1, 1'b1, 1'b0, 8'h0e);
    // Staged opmode waits for its own update, like the cycles
    wb(1'b1, smtc_pkg::ADR_STAGED_OP, 32'h00000801);
    run(2'h3, 1'b0, 1'b0, 8'h12);
    chk(32'(o_ale_used), 32'h0);
    wb(1'b1, smtc_pkg::ADR_DIRECT_CMD, cmdw(3'h3, smtc_pkg::CMD_UPDATE));
    wb(1'b0, smtc_pkg::ADR_STATUS, 32'h0);
    chk(q, 32'h30);
    run(2'h3, 1'b0, 1'b0, 8'h10);
    chk(32'(o_ale_used), 32'h1);
    test_done();
  end
endmodule
